// file: rtl/mpio_map.svh
`ifndef MPIO_MAP_SVH
`define MPIO_MAP_SVH

// register offsets on the four select lines
`define MPIO_OFS_CHAN_A_MODE1   4'h0
`define MPIO_OFS_CHAN_A_CLKSEL  4'h1
`define MPIO_OFS_CHAN_A_MODE2   4'h2
`define MPIO_OFS_AUX_CONTROL    4'h3
`define MPIO_OFS_CHANGE_FLAGS   4'h4
`define MPIO_OFS_INT_STATUS     4'h5
`define MPIO_OFS_CHAN_B_MODE1   4'h6
`define MPIO_OFS_CHAN_B_MODE2   4'h7
`define MPIO_OFS_CHAN_B_CLKSEL  4'h8
`define MPIO_OFS_OUTPUT_CONFIG  4'h9
`define MPIO_OFS_PIN_LEVELS     4'hd
`define MPIO_OFS_OUTPUT_SET     4'he
`define MPIO_OFS_OUTPUT_CLEAR   4'hf

// field positions
`define MPIO_M2_CTS_BIT         4
`define MPIO_M2_RTS_BIT         5
`define MPIO_M1_RTS_BIT         7
`define MPIO_EXT_CLK_CODE       3'h7
`define MPIO_CT_EXT_CODE        3'h0

// reset values
`define MPIO_RST_REG            8'h00
`define MPIO_RST_PINS           8'hff
`define MPIO_RST_FLAGS          4'h0

// detector sampling: main clock divided by this tap
`define MPIO_SAMPLE_DIV         96
`define MPIO_SAMPLE_LAST        7'h5f

`endif

// file: rtl/mpio_pkg.sv
package mpio_pkg;

  // one-hot bus access states
  typedef enum logic [2:0] {
    MPIO_ACC_IDLE  = 3'h1,
    MPIO_ACC_READ  = 3'h2,
    MPIO_ACC_WRITE = 3'h4
  } mpio_acc_t;

  // host side of the parallel bus
  typedef struct packed {
    logic       chipSelectN;
    logic       readStrobeN;
    logic       writeStrobeN;
    logic [3:0] regSelectLines;
    logic [7:0] dataIn;
  } mpio_host_t;

  // alternate input functions handed to the serial section
  typedef struct packed {
    logic chanAClearToSendN;
    logic chanBClearToSendN;
    logic counterExtClock;
    logic chanATxExtClock;
    logic chanARxExtClock;
    logic chanBTxExtClock;
    logic chanBRxExtClock;
  } mpio_alt_t;

  // state of the port, apart from the detectors and the sample divider
  typedef struct packed {
    mpio_acc_t  acc;
    logic [7:0] chanAMode1;
    logic [7:0] chanAMode2;
    logic [7:0] chanAClockSelect;
    logic [7:0] chanBMode1;
    logic [7:0] chanBMode2;
    logic [7:0] chanBClockSelect;
    logic [7:0] auxControl;
    logic [7:0] outputConfig;
    logic [7:0] interruptMask;
    logic [7:0] outputLatch;
    logic [3:0] changeFlags;
    logic [7:0] dataOut;
    logic       dataOeN;
    logic       interruptN;
    logic [7:0] genOutput;
    mpio_alt_t  alt;
  } mpio_state_t;

  // detector state
  typedef struct packed {
    logic primed;
    logic sample;
    logic level;
    logic changed;
  } mpio_det_t;

endpackage

// file: rtl/mpio_sample_tick.sv
`timescale 1ns/10ps
`include "mpio_map.svh"

module mpio_sample_tick
  import mpio_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // one-cycle pulse every divider period
  output logic      tick
);

  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic       tick_ff;
  logic       nxt_tick;

  // free divider, the detectors sample once per wrap
  always_comb begin
    nxt_tick = (cnt_ff == `MPIO_SAMPLE_LAST);
    nxt_cnt  = nxt_tick ? 7'h00 : cnt_ff + 7'h01;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

  tick_spacing_a: assert property (@(posedge clk) disable iff (srst)
    tick |=> !tick [*8]) else $error("sample tick too frequent");

endmodule

// file: rtl/mpio_change_det.sv
`timescale 1ns/10ps
`include "mpio_map.svh"

module mpio_change_det
  import mpio_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // sampling and pin
  input  wire logic tick,
  input  wire logic pinLevel,
  // filtered level and change pulse
  output logic      level,
  output logic      changed
);

  mpio_det_t st_ff;
  mpio_det_t nxt_st;

  // new level must be seen on two ticks running before it counts
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.changed = 1'b0;
    if (tick) begin
      nxt_st.sample = pinLevel;
      if (!st_ff.primed) begin
        // first tick after reset only learns the level, no flag
        nxt_st.primed = 1'b1;
        nxt_st.level  = pinLevel;
      end else if (pinLevel == st_ff.sample && pinLevel != st_ff.level) begin
        nxt_st.level   = pinLevel;
        nxt_st.changed = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level   = st_ff.level;
  assign changed = st_ff.changed;

  two_sample_a: assert property (@(posedge clk) disable iff (srst)
    changed |-> $past(tick) && $past(pinLevel) == level && $past(st_ff.sample, 2) == level)
    else $error("change flagged without two equal samples");

endmodule

// file: rtl/mpio_port_top.sv
// Notes on behaviour
// - select lines plus strobes move one byte
// - reset puts all pins and registers defined
// - pin level register reads inverted inputs
// - each input alternate function enabled separately
// - input 2 is counter clock on code 000
// - inputs 3,5 transmit clocks on 1110/1111
// - inputs 4,6 receive clocks on 1110/1111
// - any edge on inputs 0-3 sets flag
// - detectors sample on main clock divided 96
// - level must hold two samples to count
// - change can raise interrupt via status
// - reading change register clears its flags
// - output 0 carries channel A request-to-send
// - output 1 carries channel B request-to-send
// - config register picks outputs 2-7 functions
// - counter and discrete interrupts on outputs 3-7
// - interrupt pin gated by mask, status shows all
// - reset drives all eight outputs high
`timescale 1ns/10ps
`include "mpio_map.svh"

module mpio_port_top
  import mpio_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // host parallel bus
  input  wire mpio_host_t  hostBus,
  output logic [7:0]       dataOut,
  output logic             dataOeN,
  // pins
  input  wire logic [6:0]  genInput,
  output logic [7:0]       genOutput,
  output logic             interruptN,
  // from the serial section
  input  wire logic        chanARequestToSendN,
  input  wire logic        chanBRequestToSendN,
  input  wire logic        counterOut,
  input  wire logic        op2Source,
  input  wire logic [3:0]  discreteIrqN,
  input  wire logic [6:0]  serialEvents,
  // to the serial section
  output mpio_alt_t        altInputs
);

  mpio_state_t q_ff;
  mpio_state_t nxt_q;

  logic       sampleTick;
  logic [3:0] detLevel;
  logic [3:0] detChanged;
  logic       rdStart;
  logic       wrStart;
  logic       chgIrq;
  logic [7:0] statusBits;
  logic [7:0] rdData;

  mpio_sample_tick u_tick (
    .clk  (clk),
    .srst (srst),
    .tick (sampleTick)
  );

  // one detector per watched input
  for (genvar i = 0; i < 4; i++) begin : g_det
    mpio_change_det u_det (
      .clk      (clk),
      .srst     (srst),
      .tick     (sampleTick),
      .pinLevel (genInput[i]),
      .level    (detLevel[i]),
      .changed  (detChanged[i])
    );
  end

  // access starts on the first cycle strobe and select are both low
  always_comb begin
    rdStart = (q_ff.acc == MPIO_ACC_IDLE) && !hostBus.chipSelectN
              && !hostBus.readStrobeN;
    wrStart = (q_ff.acc == MPIO_ACC_IDLE) && !hostBus.chipSelectN
              && !hostBus.writeStrobeN && hostBus.readStrobeN;
  end

  // status: change bit on top, serial events below, all unmasked
  always_comb begin
    chgIrq     = |(q_ff.changeFlags & q_ff.auxControl[3:0]);
    statusBits = {chgIrq, serialEvents};
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    case (hostBus.regSelectLines)
      `MPIO_OFS_CHAN_A_MODE1:  rdData = q_ff.chanAMode1;
      `MPIO_OFS_CHAN_A_MODE2:  rdData = q_ff.chanAMode2;
      `MPIO_OFS_CHAN_A_CLKSEL: rdData = q_ff.chanAClockSelect;
      `MPIO_OFS_CHAN_B_MODE1:  rdData = q_ff.chanBMode1;
      `MPIO_OFS_CHAN_B_MODE2:  rdData = q_ff.chanBMode2;
      `MPIO_OFS_CHAN_B_CLKSEL: rdData = q_ff.chanBClockSelect;
      `MPIO_OFS_CHANGE_FLAGS:  rdData = {q_ff.changeFlags, detLevel};
      `MPIO_OFS_INT_STATUS:    rdData = statusBits;
      `MPIO_OFS_PIN_LEVELS:    rdData = {1'b0, ~genInput};
      default:                 rdData = 8'h00;
    endcase
  end

  always_comb begin
    nxt_q = q_ff;

    // access sequencing, one register move per strobe
    case (q_ff.acc)
      MPIO_ACC_IDLE: begin
        if (rdStart) begin
          nxt_q.acc = MPIO_ACC_READ;
        end else if (wrStart) begin
          nxt_q.acc = MPIO_ACC_WRITE;
        end
      end
      MPIO_ACC_READ: begin
        if (hostBus.chipSelectN || hostBus.readStrobeN) begin
          nxt_q.acc = MPIO_ACC_IDLE;
        end
      end
      MPIO_ACC_WRITE: begin
        if (hostBus.chipSelectN || hostBus.writeStrobeN) begin
          nxt_q.acc = MPIO_ACC_IDLE;
        end
      end
      default: begin
        nxt_q.acc = MPIO_ACC_IDLE;
      end
    endcase

    // read data is frozen at strobe start, so a clear cannot race it
    if (rdStart) begin
      nxt_q.dataOut = rdData;
    end
    nxt_q.dataOeN = (nxt_q.acc != MPIO_ACC_READ);

    // flags clear on read, a new change in the same cycle still lands
    if (rdStart && hostBus.regSelectLines == `MPIO_OFS_CHANGE_FLAGS) begin
      nxt_q.changeFlags = `MPIO_RST_FLAGS;
    end
    nxt_q.changeFlags = nxt_q.changeFlags | detChanged;

    // register writes, taken once at strobe start
    if (wrStart) begin
      case (hostBus.regSelectLines)
        `MPIO_OFS_CHAN_A_MODE1:  nxt_q.chanAMode1       = hostBus.dataIn;
        `MPIO_OFS_CHAN_A_MODE2:  nxt_q.chanAMode2       = hostBus.dataIn;
        `MPIO_OFS_CHAN_A_CLKSEL: nxt_q.chanAClockSelect = hostBus.dataIn;
        `MPIO_OFS_CHAN_B_MODE1:  nxt_q.chanBMode1       = hostBus.dataIn;
        `MPIO_OFS_CHAN_B_MODE2:  nxt_q.chanBMode2       = hostBus.dataIn;
        `MPIO_OFS_CHAN_B_CLKSEL: nxt_q.chanBClockSelect = hostBus.dataIn;
        `MPIO_OFS_AUX_CONTROL:   nxt_q.auxControl       = hostBus.dataIn;
        `MPIO_OFS_INT_STATUS:    nxt_q.interruptMask    = hostBus.dataIn;
        `MPIO_OFS_OUTPUT_CONFIG: nxt_q.outputConfig     = hostBus.dataIn;
        `MPIO_OFS_OUTPUT_SET:
          nxt_q.outputLatch = q_ff.outputLatch | hostBus.dataIn;
        `MPIO_OFS_OUTPUT_CLEAR:
          nxt_q.outputLatch = q_ff.outputLatch & ~hostBus.dataIn;
        default: begin
        end
      endcase
    end

    // interrupt pin only for unmasked events
    nxt_q.interruptN = !(|(statusBits & q_ff.interruptMask));

    // pins show the complement of the latch unless an alternate owns them
    nxt_q.genOutput = ~q_ff.outputLatch;
    if (q_ff.chanAMode2[`MPIO_M2_RTS_BIT] || q_ff.chanAMode1[`MPIO_M1_RTS_BIT]) begin
      nxt_q.genOutput[0] = chanARequestToSendN;
    end
    if (q_ff.chanBMode2[`MPIO_M2_RTS_BIT] || q_ff.chanBMode1[`MPIO_M1_RTS_BIT]) begin
      nxt_q.genOutput[1] = chanBRequestToSendN;
    end
    if (q_ff.outputConfig[1:0] != 2'h0) begin
      nxt_q.genOutput[2] = op2Source;
    end
    if (q_ff.outputConfig[3:2] != 2'h0) begin
      nxt_q.genOutput[3] = counterOut;
    end
    for (int k = 0; k < 4; k++) begin
      if (q_ff.outputConfig[4 + k]) begin
        nxt_q.genOutput[4 + k] = discreteIrqN[k];
      end
    end

    // alternate input functions; a disabled one is held at 0
    nxt_q.alt.chanAClearToSendN = q_ff.chanAMode2[`MPIO_M2_CTS_BIT] ?
                                  genInput[0] : 1'b0;
    nxt_q.alt.chanBClearToSendN = q_ff.chanBMode2[`MPIO_M2_CTS_BIT] ?
                                  genInput[1] : 1'b0;
    nxt_q.alt.counterExtClock = (q_ff.auxControl[6:4] == `MPIO_CT_EXT_CODE) ?
                                genInput[2] : 1'b0;
    nxt_q.alt.chanATxExtClock = (q_ff.chanAClockSelect[3:1] == `MPIO_EXT_CLK_CODE) ?
                                genInput[3] : 1'b0;
    nxt_q.alt.chanBTxExtClock = (q_ff.chanBClockSelect[3:1] == `MPIO_EXT_CLK_CODE) ?
                                genInput[5] : 1'b0;
    nxt_q.alt.chanARxExtClock = (q_ff.chanAClockSelect[7:5] == `MPIO_EXT_CLK_CODE) ?
                                genInput[4] : 1'b0;
    nxt_q.alt.chanBRxExtClock = (q_ff.chanBClockSelect[7:5] == `MPIO_EXT_CLK_CODE) ?
                                genInput[6] : 1'b0;
  end

  // all state resets together; pins go high, bus released
  always_ff @(posedge clk) begin
    if (srst) begin
      q_ff                  <= '0;
      q_ff.acc              <= MPIO_ACC_IDLE;
      q_ff.chanAMode1       <= `MPIO_RST_REG;
      q_ff.chanAMode2       <= `MPIO_RST_REG;
      q_ff.outputLatch      <= `MPIO_RST_REG;
      q_ff.changeFlags      <= `MPIO_RST_FLAGS;
      q_ff.dataOeN          <= 1'b1;
      q_ff.interruptN       <= 1'b1;
      q_ff.genOutput        <= `MPIO_RST_PINS;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // every output straight from the state flops
  assign dataOut    = q_ff.dataOut;
  assign dataOeN    = q_ff.dataOeN;
  assign genOutput  = q_ff.genOutput;
  assign interruptN = q_ff.interruptN;
  assign altInputs  = q_ff.alt;

  // bus, reset, routing, flag, latch and interrupt checks; read data stands from the edge after the start
  read_drives_bus_a: assert property (@(posedge clk) disable iff (srst)
    rdStart |=> !dataOeN && dataOut == $past(rdData))
    else $error("read did not drive the bus");

  reset_pins_high_a: assert property (@(posedge clk)
    srst |=> genOutput == 8'hff && interruptN && dataOeN && q_ff.outputLatch == 8'h00)
    else $error("reset left a pin low");

  pin_level_inv_a: assert property (@(posedge clk) disable iff (srst)
    rdStart && hostBus.regSelectLines == 4'hd |=> dataOut == {1'b0, ~$past(genInput)})
    else $error("pin level not inverted");

  cts_route_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.chanAMode2[4] |=> altInputs.chanAClearToSendN == $past(genInput[0]))
    else $error("clear-to-send A not routed");

  counter_clk_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.auxControl[6:4] != 3'h0 |=> !altInputs.counterExtClock)
    else $error("counter clock leaked while disabled");

  tx_clk_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.chanBClockSelect[3:0] == 4'he |=> altInputs.chanBTxExtClock == $past(genInput[5]))
    else $error("transmit clock B not routed");

  rx_clk_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.chanAClockSelect[7:4] == 4'hf |=> altInputs.chanARxExtClock == $past(genInput[4]))
    else $error("receive clock A not routed");

  flag_clear_a: assert property (@(posedge clk) disable iff (srst)
    rdStart && hostBus.regSelectLines == 4'h4 |=> q_ff.changeFlags == $past(detChanged))
    else $error("change flags not cleared by read");

  rts_route_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.chanAMode1[7] && !q_ff.chanAMode2[5] |=> genOutput[0] == $past(chanARequestToSendN))
    else $error("request-to-send A not on output 0");

  set_latch_a: assert property (@(posedge clk) disable iff (srst)
    wrStart && hostBus.regSelectLines == 4'he |=>
      q_ff.outputLatch == ($past(q_ff.outputLatch) | $past(hostBus.dataIn)))
    else $error("set register did not set latch");

  int_mask_a: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> interruptN == !(|($past(statusBits) & $past(q_ff.interruptMask))))
    else $error("interrupt pin disagrees with mask");

  // latch, routing, status, flag and bus checks; each looks one edge past its cause
  clr_latch_a: assert property (@(posedge clk) disable iff (srst)
    wrStart && hostBus.regSelectLines == 4'hf |=>
      q_ff.outputLatch == ($past(q_ff.outputLatch) & ~$past(hostBus.dataIn)))
    else $error("clear register did not clear latch");

  rts_b_route_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.chanBMode2[5] || q_ff.chanBMode1[7] |=> genOutput[1] == $past(chanBRequestToSendN))
    else $error("request-to-send B not on output 1");

  op2_route_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.outputConfig[1:0] != 2'h0 |=> genOutput[2] == $past(op2Source))
    else $error("output 2 not on its alternate source");

  ct_out_route_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.outputConfig[3:2] != 2'h0 |=> genOutput[3] == $past(counterOut))
    else $error("counter output not on output 3");

  irq_out4_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.outputConfig[4] |=> genOutput[4] == $past(discreteIrqN[0]))
    else $error("discrete interrupt not on output 4");

  irq_out7_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.outputConfig[7] |=> genOutput[7] == $past(discreteIrqN[3]))
    else $error("discrete interrupt not on output 7");

  plain_outputs_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.outputConfig[7:4] == 4'h0 |=> genOutput[7:4] == ~$past(q_ff.outputLatch[7:4]))
    else $error("plain outputs not from latch");

  chg_status_a: assert property (@(posedge clk) disable iff (srst)
    rdStart && hostBus.regSelectLines == 4'h5 && (|(q_ff.changeFlags & q_ff.auxControl[3:0]))
      |=> dataOut[7])
    else $error("enabled change missing from status");

  flag_set_a: assert property (@(posedge clk) disable iff (srst)
    (|detChanged) |=> (q_ff.changeFlags & $past(detChanged)) == $past(detChanged))
    else $error("detected change did not set flag");

  flags_hold_a: assert property (@(posedge clk) disable iff (srst)
    !(rdStart && hostBus.regSelectLines == 4'h4) |=>
      (q_ff.changeFlags & $past(q_ff.changeFlags)) == $past(q_ff.changeFlags))
    else $error("change flag dropped without a read");

  tx_clk_off_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.chanAClockSelect[3:1] != 3'h7 |=> !altInputs.chanATxExtClock)
    else $error("transmit clock A leaked while disabled");

  rx_clk_off_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.chanBClockSelect[7:5] != 3'h7 |=> !altInputs.chanBRxExtClock)
    else $error("receive clock B leaked while disabled");

  cts_off_a: assert property (@(posedge clk) disable iff (srst)
    !q_ff.chanBMode2[4] |=> !altInputs.chanBClearToSendN)
    else $error("clear-to-send B leaked while disabled");

  write_no_drive_a: assert property (@(posedge clk) disable iff (srst)
    wrStart |=> dataOeN)
    else $error("write drove the data bus");

  read_release_a: assert property (@(posedge clk) disable iff (srst)
    q_ff.acc == MPIO_ACC_READ && hostBus.readStrobeN |=> dataOeN)
    else $error("bus still driven after read strobe rose");

endmodule

// file: testbench/mpio_host_model.sv
`timescale 1ns/10ps

module mpio_host_model
  import mpio_pkg::*;
(
  // clock
  input  wire logic       clk,
  // device answer
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOeN,
  // host bus
  output mpio_host_t      hostBus
);
  // idle bus at time zero
  initial begin
    hostBus = {1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
  end

  // one byte write; no answer signal, so strobe stands one sampled edge
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clk);
    hostBus.chipSelectN    <= 1'b0;
    hostBus.writeStrobeN   <= 1'b0;
    hostBus.regSelectLines <= addr;
    hostBus.dataIn         <= data;
    @(posedge clk);
    hostBus.chipSelectN    <= 1'b1;
    hostBus.writeStrobeN   <= 1'b1;
    // released lines show garbage, not the last value
    hostBus.regSelectLines <= ~addr;
    hostBus.dataIn         <= ~data;
    @(posedge clk);
  endtask

  // one byte read; held until the device drives the bus or eight edges pass
  task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
    int i;
    data = 8'hxx;
    @(posedge clk);
    hostBus.chipSelectN    <= 1'b0;
    hostBus.readStrobeN    <= 1'b0;
    hostBus.regSelectLines <= addr;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (dataOeN === 1'b0) begin
        data = dataOut;
        break;
      end
    end
    hostBus.chipSelectN    <= 1'b1;
    hostBus.readStrobeN    <= 1'b1;
    hostBus.regSelectLines <= ~addr;
    // bus turnaround before the next access
    @(posedge clk);
    @(posedge clk);
  endtask
endmodule

// file: testbench/multipurpose_io_port_test.sv
`timescale 1ns/10ps
`include "mpio_map.svh"

module multipurpose_io_port_test
  import mpio_pkg::*;
;
  logic       clk;
  logic       srst;
  mpio_host_t hostBus;
  logic [7:0] dataOut;
  logic       dataOeN;
  logic [6:0] genInput;
  logic [7:0] genOutput;
  logic       interruptN;
  logic       chanARequestToSendN;
  logic       chanBRequestToSendN;
  logic       counterOut;
  logic       op2Source;
  logic [3:0] discreteIrqN;
  logic [6:0] serialEvents;
  mpio_alt_t  altInputs;
  logic [7:0] rd;
  int         n_errors;
  int         n_tests;

  mpio_port_top mpio_port_top_inst (
    .clk(clk), .srst(srst), .hostBus(hostBus), .dataOut(dataOut), .dataOeN(dataOeN),
    .genInput(genInput), .genOutput(genOutput), .interruptN(interruptN),
    .chanARequestToSendN(chanARequestToSendN), .chanBRequestToSendN(chanBRequestToSendN),
    .counterOut(counterOut), .op2Source(op2Source), .discreteIrqN(discreteIrqN),
    .serialEvents(serialEvents), .altInputs(altInputs)
  );

  mpio_host_model mpio_host_model_inst (
    .clk(clk), .dataOut(dataOut), .dataOeN(dataOeN), .hostBus(hostBus)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic give_verdict();
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    mpio_host_model_inst.write_reg(a, d);
  endtask

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
    mpio_host_model_inst.read_reg(a, rd);
    check(name, rd, exp);
    check("dataOeN after read", {7'h0, dataOeN}, 8'h01);
  endtask

  // upper nibble of the change register holds the flags
  task automatic flags_chk(input logic [3:0] exp);
    mpio_host_model_inst.read_reg(`MPIO_OFS_CHANGE_FLAGS, rd);
    check("changeFlags", {4'h0, rd[7:4]}, {4'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reset_chk();
    check("genOutput reset", genOutput, 8'hff);
    check("interruptN reset", {7'h0, interruptN}, 8'h01);
    check("dataOeN reset", {7'h0, dataOeN}, 8'h01);
    check("altInputs reset", {1'b0, altInputs}, 8'h00);
  endtask

  // a hang counts against the run
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    genInput = 7'h7f;
    chanARequestToSendN = 1'b0;
    chanBRequestToSendN = 1'b1;
    counterOut = 1'b0;
    op2Source = 1'b1;
    discreteIrqN = 4'ha;
    serialEvents = 7'h05;
    n_errors = 0;
    n_tests = 0;
    cyc(5);
    reset_chk();
    srst <= 1'b0;
    // detectors learn levels on the first tick
    cyc(300);
    flags_chk(4'h0);
    // register file, write-only and unmapped places
    rd_chk("mode1 A reset", `MPIO_OFS_CHAN_A_MODE1, 8'h00);
    wr(`MPIO_OFS_CHAN_A_MODE1, 8'h5a);
    rd_chk("mode1 A", `MPIO_OFS_CHAN_A_MODE1, 8'h5a);
    wr(`MPIO_OFS_CHAN_A_MODE1, 8'h00);
    wr(`MPIO_OFS_OUTPUT_CONFIG, 8'h00);
    rd_chk("config write-only", `MPIO_OFS_OUTPUT_CONFIG, 8'h00);
    rd_chk("unmapped", 4'ha, 8'h00);
    // complemented pin levels, then flags on inputs 1 and 3
    genInput <= 7'h55;
    cyc(2);
    rd_chk("pin levels", `MPIO_OFS_PIN_LEVELS, 8'h2a);
    cyc(300);
    flags_chk(4'ha);
    flags_chk(4'h0);
    // two samples at the divided rate before a change counts
    genInput[0] <= 1'b0;
    cyc(90);
    flags_chk(4'h0);
    cyc(300);
    flags_chk(4'h1);
    // a pulse shorter than one sample period leaves no flag
    genInput[2] <= 1'b0;
    cyc(20);
    genInput[2] <= 1'b1;
    cyc(300);
    flags_chk(4'h0);
    // change interrupt on input 1, unmasked
    wr(`MPIO_OFS_AUX_CONTROL, 8'h02);
    wr(`MPIO_OFS_INT_STATUS, 8'h80);
    genInput[1] <= 1'b1;
    cyc(300);
    check("interruptN change", {7'h0, interruptN}, 8'h00);
    rd_chk("status change", `MPIO_OFS_INT_STATUS, 8'h85);
    flags_chk(4'h2);
    cyc(3);
    check("interruptN cleared", {7'h0, interruptN}, 8'h01);
    rd_chk("status cleared", `MPIO_OFS_INT_STATUS, 8'h05);
    // masked: status still shows it, pin stays quiet
    wr(`MPIO_OFS_INT_STATUS, 8'h00);
    genInput[1] <= 1'b0;
    cyc(300);
    check("interruptN masked", {7'h0, interruptN}, 8'h01);
    rd_chk("status masked", `MPIO_OFS_INT_STATUS, 8'h85);
    wr(`MPIO_OFS_INT_STATUS, 8'h01);
    cyc(3);
    check("interruptN event 0", {7'h0, interruptN}, 8'h00);
    wr(`MPIO_OFS_INT_STATUS, 8'h00);
    flags_chk(4'h2);
    // alternate inputs, each enabled on its own
    wr(`MPIO_OFS_CHAN_A_MODE2, 8'h30);
    wr(`MPIO_OFS_CHAN_B_MODE2, 8'h10);
    wr(`MPIO_OFS_CHAN_A_CLKSEL, 8'hee);
    wr(`MPIO_OFS_CHAN_B_CLKSEL, 8'hff);
    genInput <= 7'h7f;
    cyc(3);
    check("alt all on", {1'b0, altInputs}, 8'h7f);
    genInput <= 7'h00;
    cyc(3);
    check("alt follow", {1'b0, altInputs}, 8'h00);
    genInput <= 7'h7f;
    wr(`MPIO_OFS_CHAN_A_CLKSEL, 8'hed);
    wr(`MPIO_OFS_AUX_CONTROL, 8'h12);
    cyc(2);
    check("alt partial", {1'b0, altInputs}, 8'h67);
    rd_chk("pins with alt", `MPIO_OFS_PIN_LEVELS, 8'h00);
    // every output on its alternate source
    wr(`MPIO_OFS_CHAN_B_MODE1, 8'h80);
    wr(`MPIO_OFS_OUTPUT_CONFIG, 8'hff);
    cyc(2);
    check("outputs alt", genOutput, 8'ha6);
    chanARequestToSendN <= 1'b1;
    chanBRequestToSendN <= 1'b0;
    counterOut <= 1'b1;
    cyc(3);
    check("outputs alt swap", genOutput, 8'had);
    // plain outputs through the set and clear registers
    wr(`MPIO_OFS_OUTPUT_CONFIG, 8'h00);
    wr(`MPIO_OFS_CHAN_A_MODE2, 8'h00);
    wr(`MPIO_OFS_CHAN_B_MODE1, 8'h00);
    wr(`MPIO_OFS_OUTPUT_SET, 8'h0f);
    cyc(2);
    check("outputs set", genOutput, 8'hf0);
    wr(`MPIO_OFS_OUTPUT_CLEAR, 8'h03);
    cyc(2);
    check("outputs clear", genOutput, 8'hf3);
    wr(`MPIO_OFS_OUTPUT_CONFIG, 8'h10);
    cyc(2);
    check("output 4 irq", genOutput, 8'he3);
    // second reset in mid-run
    srst <= 1'b1;
    cyc(5);
    reset_chk();
    srst <= 1'b0;
    rd_chk("mode2 A after reset", `MPIO_OFS_CHAN_A_MODE2, 8'h00);
    give_verdict();
  end
endmodule
